// ==== shared/msp_pkg.sv ====
// Package with the constants, types and helpers of the mode select and port mux block.
package msp_pkg;

  // ---------------------------------------------------------------------------
  // Port geometry
  // ---------------------------------------------------------------------------
  localparam int NUM_PORTS = 8;
  localparam int PORT_W    = 8;
  localparam int PORT_A    = 0;
  localparam int PORT_B    = 1;
  localparam int PORT_C    = 2;
  localparam int PORT_D    = 3;
  localparam int PORT_E    = 4;
  localparam int PORT_F    = 5;
  localparam int PORT_G    = 6;
  localparam int PORT_H    = 7;

  // Which lines exist on each port, and which of them may be driven.
  localparam logic [7:0] FULL_MASK           = 8'hff;
  localparam logic [7:0] NONE_MASK           = 8'h00;
  localparam logic [7:0] PORT_D_MASK         = 8'h3f;
  localparam logic [7:0] PORT_G_REDUCED_MASK = 8'h80;
  localparam logic [7:0] PORT_H_REDUCED_MASK = 8'h0f;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] GPIO_DATA_RST = 8'h00;
  localparam logic [7:0] GPIO_DIR_RST  = 8'h00;

  // ---------------------------------------------------------------------------
  // Bus-cycle timing: one bus cycle is four oscillator ticks
  // ---------------------------------------------------------------------------
  localparam int         CLK_PER_BUS  = 4;
  localparam int         PH_W         = $clog2(CLK_PER_BUS);
  localparam logic [1:0] PH_LAST      = 2'h3;
  localparam logic [1:0] E_HIGH_FIRST = 2'h2;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SINGLE_CHIP,
    MODE_EXPANDED,
    MODE_BOOTSTRAP,
    MODE_SPECIAL_TEST
  } msp_mode_t;

  typedef struct packed {
    logic [7:0] en;
    logic [7:0] out;
    logic [7:0] oe;
  } msp_spec_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } msp_pad_t;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Strap decode: pin B high picks a normal mode, pin A splits each pair.
  function automatic msp_mode_t msp_decode_mode(input logic pin_a, input logic pin_b);
    if (pin_b) begin
      return pin_a ? MODE_EXPANDED : MODE_SINGLE_CHIP;
    end
    return pin_a ? MODE_SPECIAL_TEST : MODE_BOOTSTRAP;
  endfunction

  // True for the modes in which the external bus is brought out.
  function automatic logic msp_is_expanded(input msp_mode_t mode);
    return (mode == MODE_EXPANDED) || (mode == MODE_SPECIAL_TEST);
  endfunction

  // Lines present on a port for the full or the reduced-pin variant.
  function automatic logic [7:0] msp_pin_mask(input int idx, input logic reduced);
    logic [7:0] mask;
    mask = FULL_MASK;
    if (idx == PORT_D) begin
      mask = PORT_D_MASK;
    end else if (reduced && (idx == PORT_G)) begin
      mask = PORT_G_REDUCED_MASK;
    end else if (reduced && (idx == PORT_H)) begin
      mask = PORT_H_REDUCED_MASK;
    end
    return mask;
  endfunction

endpackage

// ==== verilog/msp_port_mux.sv ====
// One port's pad driver: chooses between GPIO and special function per line.
`timescale 1ns/1ps
module msp_port_mux #(
  parameter logic [7:0] PIN_MASK   = 8'hff,
  parameter logic [7:0] DRIVE_MASK = 8'hff
) (
  input  wire logic               mclk_i,
  input  wire logic               rst_n_i,
  input  wire logic [7:0]         gpio_data_i,
  input  wire logic [7:0]         gpio_dir_i,
  input  wire msp_pkg::msp_spec_t spec_i,
  output msp_pkg::msp_pad_t       pad_o
);

  logic [7:0] out_next;
  logic [7:0] oe_next;

  // A line with its special function off falls back to the GPIO data and direction.
  always_comb begin
    out_next = ((spec_i.en & spec_i.out) | (~spec_i.en & gpio_data_i)) & PIN_MASK;
    oe_next  = ((spec_i.en & spec_i.oe) | (~spec_i.en & gpio_dir_i)) & PIN_MASK & DRIVE_MASK;
  end

  // Pad drive is registered so the pins never see decode glitches.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pad_o <= '0;
    end else begin
      pad_o.out <= out_next;
      pad_o.oe  <= oe_next;
    end
  end

endmodule

// ==== verilog/msp_mode_port_top.sv ====
// Mode strap capture, bus-cycle clock, opcode-fetch marker and port routing.
`timescale 1ns/1ps
module msp_mode_port_top #(
  parameter logic REDUCED_PINS = 1'b0
) (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  mode_pin_a_i,
  input  wire logic                  mode_pin_b_i,
  output msp_pkg::msp_mode_t         mode_o,
  output logic                       mode_valid_o,
  output logic                       e_clk_o,
  input  wire logic                  opcode_fetch_i,
  input  wire logic                  marker_drive_high_option_i,
  output logic                       opcode_fetch_marker_o,
  output logic                       opcode_fetch_marker_oe_o,
  input  wire logic [7:0][7:0]       pad_in_i,
  output logic      [7:0][7:0]       pad_out_o,
  output logic      [7:0][7:0]       pad_oe_o,
  input  wire logic                  port_wr_i,
  input  wire logic                  port_wsel_dir_i,
  input  wire logic [2:0]            port_waddr_i,
  input  wire logic [7:0]            port_wdata_i,
  input  wire logic                  port_rsel_dir_i,
  input  wire logic [2:0]            port_raddr_i,
  output logic      [7:0]            port_rdata_o,
  input  wire logic [15:0]           ext_addr_i,
  input  wire logic [18:13]          ext_addr_hi_i,
  input  wire logic [5:0]            ext_addr_hi_en_i,
  input  wire logic                  ext_rw_i,
  input  wire logic [7:0]            ext_data_out_i,
  input  wire logic                  ext_data_oe_i,
  output logic      [7:0]            ext_data_in_o,
  input  wire logic [5:2]            oc_en_i,
  input  wire logic [5:1]            oc_level_i,
  input  wire logic [7:3]            oc1_mask_i,
  input  wire logic                  ic4_select_i,
  input  wire logic                  pai_en_i,
  output logic      [4:1]            input_capture_o,
  output logic                       pulse_accumulator_input_o,
  input  wire logic [5:0]            serial_en_i,
  input  wire logic [5:0]            serial_out_i,
  input  wire logic [5:0]            serial_oe_i,
  output logic      [5:0]            serial_in_o,
  input  wire logic                  adc_en_i,
  output logic      [7:0]            adc_inputs_o,
  input  wire logic [3:0]            pwm_en_i,
  input  wire logic [3:0]            pwm_i,
  input  wire logic                  io_chip_select_en_i,
  input  wire logic                  io_chip_select_i,
  input  wire logic                  program_chip_select_en_i,
  input  wire logic                  program_chip_select_i
);

  typedef enum logic {ST_CAPTURE, ST_RUN} msp_state_t;

  msp_state_t           state_reg;
  msp_pkg::msp_mode_t   mode_reg;
  logic                 mode_valid_reg;
  logic [1:0]           ph_reg;
  logic [1:0]           ph_next;
  logic                 fetch_reg;
  logic                 marker_low_next;
  logic                 marker_high_next;
  logic                 marker_allowed;
  logic                 exp_active;
  logic [7:0]           data_reg [8];
  logic [7:0]           dir_reg [8];
  logic [7:0]           pad_in_reg [8];
  msp_pkg::msp_spec_t   spec [8];
  msp_pkg::msp_pad_t    pad_drv [8];

  // ---------------------------------------------------------------------------
  // Mode strap capture
  // ---------------------------------------------------------------------------
  // The straps are read on the first edge after reset release; flops under reset only
  // take constants, so the board must keep the straps steady through that edge.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg      <= ST_CAPTURE;
      mode_reg       <= msp_pkg::MODE_SINGLE_CHIP;
      mode_valid_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_CAPTURE: begin
          mode_reg       <= msp_pkg::msp_decode_mode(mode_pin_a_i, mode_pin_b_i);
          mode_valid_reg <= 1'b1;
          state_reg      <= ST_RUN;
        end
        ST_RUN: begin
          state_reg <= ST_RUN;
        end
        default: begin
          state_reg <= ST_RUN;
        end
      endcase
    end
  end

  assign mode_o       = mode_reg;
  assign mode_valid_o = mode_valid_reg;
  // Bus routing follows the latched mode only; before capture ports B, C, F and G stay GPIO.
  assign exp_active     = mode_valid_reg && msp_pkg::msp_is_expanded(mode_reg);
  assign marker_allowed = exp_active;

  // ---------------------------------------------------------------------------
  // Bus-cycle clock and opcode-fetch marker
  // ---------------------------------------------------------------------------
  // Next phase and the next marker state, worked out a tick ahead so the pins are flops.
  always_comb begin
    ph_next          = ph_reg + 2'h1;
    marker_low_next  = (ph_reg == msp_pkg::PH_LAST) ? opcode_fetch_i : fetch_reg;
    marker_high_next = (ph_reg == msp_pkg::PH_LAST) && fetch_reg && !opcode_fetch_i &&
                       marker_drive_high_option_i;
  end

  // Phase counter divides the oscillator by four; E is high in the data half.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_reg    <= msp_pkg::PH_LAST;
      e_clk_o   <= 1'b0;
      fetch_reg <= 1'b0;
    end else begin
      ph_reg  <= ph_next;
      e_clk_o <= (ph_next >= msp_pkg::E_HIGH_FIRST);
      if (ph_reg == msp_pkg::PH_LAST) begin
        fetch_reg <= opcode_fetch_i;
      end
    end
  end

  // Open drain: low for the whole fetch cycle, optionally high for the first quarter after.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      opcode_fetch_marker_o    <= 1'b1;
      opcode_fetch_marker_oe_o <= 1'b0;
    end else begin
      opcode_fetch_marker_o    <= !marker_low_next;
      opcode_fetch_marker_oe_o <= marker_allowed && (marker_low_next || marker_high_next);
    end
  end

  // ---------------------------------------------------------------------------
  // GPIO data and direction store
  // ---------------------------------------------------------------------------
  // Only software writes touch the stored data, so turning a function off restores it.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < msp_pkg::NUM_PORTS; i++) begin
        data_reg[i] <= msp_pkg::GPIO_DATA_RST;
        dir_reg[i]  <= msp_pkg::GPIO_DIR_RST;
      end
    end else if (port_wr_i) begin
      if (port_wsel_dir_i) begin
        dir_reg[port_waddr_i] <= port_wdata_i;
      end else begin
        data_reg[port_waddr_i] <= port_wdata_i;
      end
    end
  end

  // Pad inputs are captured once and shared by readback and peripheral inputs.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < msp_pkg::NUM_PORTS; i++) begin
        pad_in_reg[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < msp_pkg::NUM_PORTS; i++) begin
        pad_in_reg[i] <= pad_in_i[i] & msp_pkg::msp_pin_mask(i, REDUCED_PINS);
      end
    end
  end

  // Readback: output lines show stored data, input lines show the pin.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_rdata_o <= 8'h00;
    end else if (port_rsel_dir_i) begin
      port_rdata_o <= dir_reg[port_raddr_i] & msp_pkg::msp_pin_mask(32'(port_raddr_i), REDUCED_PINS);
    end else begin
      port_rdata_o <= ((dir_reg[port_raddr_i] & data_reg[port_raddr_i]) |
                       (~dir_reg[port_raddr_i] & pad_in_reg[port_raddr_i])) &
                      msp_pkg::msp_pin_mask(32'(port_raddr_i), REDUCED_PINS);
    end
  end

  // ---------------------------------------------------------------------------
  // Special function routing
  // ---------------------------------------------------------------------------
  // Builds enable, value and drive for every line; unlisted ports stay GPIO.
  always_comb begin
    for (int i = 0; i < msp_pkg::NUM_PORTS; i++) begin
      spec[i] = '0;
    end
    // Port A: compares 5..2 on bits 3..6, OC1 may override bits 3..7.
    spec[msp_pkg::PORT_A].en[3]  = oc_en_i[5] && !ic4_select_i;
    spec[msp_pkg::PORT_A].out[3] = oc_level_i[5];
    spec[msp_pkg::PORT_A].en[4]  = oc_en_i[4];
    spec[msp_pkg::PORT_A].out[4] = oc_level_i[4];
    spec[msp_pkg::PORT_A].en[5]  = oc_en_i[3];
    spec[msp_pkg::PORT_A].out[5] = oc_level_i[3];
    spec[msp_pkg::PORT_A].en[6]  = oc_en_i[2];
    spec[msp_pkg::PORT_A].out[6] = oc_level_i[2];
    spec[msp_pkg::PORT_A].oe     = 8'hf8;
    spec[msp_pkg::PORT_A].en[3]  = spec[msp_pkg::PORT_A].en[3] | ic4_select_i;
    spec[msp_pkg::PORT_A].oe[3]  = !ic4_select_i || oc1_mask_i[3];
    spec[msp_pkg::PORT_A].en[7]  = pai_en_i;
    spec[msp_pkg::PORT_A].oe[7]  = oc1_mask_i[7];
    for (int b = 3; b < 8; b++) begin
      if (oc1_mask_i[b]) begin
        spec[msp_pkg::PORT_A].en[b]  = 1'b1;
        spec[msp_pkg::PORT_A].out[b] = oc_level_i[1];
        spec[msp_pkg::PORT_A].oe[b]  = 1'b1;
      end
    end
    // Ports B, F and C carry the external address and data bus.
    spec[msp_pkg::PORT_B] = '{en: {8{exp_active}}, out: ext_addr_i[15:8], oe: 8'hff};
    spec[msp_pkg::PORT_F] = '{en: {8{exp_active}}, out: ext_addr_i[7:0], oe: 8'hff};
    spec[msp_pkg::PORT_C] = '{en: {8{exp_active}}, out: ext_data_out_i,
                              oe: {8{ext_data_oe_i}}};
    // Port D: RxD, TxD, MISO, MOSI, SCK, SS in bit order.
    spec[msp_pkg::PORT_D] = '{en: {2'h0, serial_en_i}, out: {2'h0, serial_out_i},
                              oe: {2'h0, serial_oe_i}};
    // Port G: read/write on bit 7, expansion address on bits 0..5, bit 6 plain.
    spec[msp_pkg::PORT_G].en  = {exp_active, 1'b0, ext_addr_hi_en_i & {6{exp_active}}};
    spec[msp_pkg::PORT_G].out = {ext_rw_i, 1'b0, ext_addr_hi_i};
    spec[msp_pkg::PORT_G].oe  = 8'hbf;
    // Port H: PWM on bits 0..3, chip selects on bits 4 and 7.
    spec[msp_pkg::PORT_H].en  = {program_chip_select_en_i, 2'h0, io_chip_select_en_i,
                                 pwm_en_i};
    spec[msp_pkg::PORT_H].out = {program_chip_select_i, 2'h0, io_chip_select_i, pwm_i};
    spec[msp_pkg::PORT_H].oe  = 8'h9f;
  end

  // Peripheral-facing inputs taken from the captured pads.
  assign ext_data_in_o             = pad_in_reg[msp_pkg::PORT_C];
  assign serial_in_o               = pad_in_reg[msp_pkg::PORT_D][5:0];
  assign input_capture_o           = {pad_in_reg[msp_pkg::PORT_A][3] & ic4_select_i,
                                      pad_in_reg[msp_pkg::PORT_A][0],
                                      pad_in_reg[msp_pkg::PORT_A][1],
                                      pad_in_reg[msp_pkg::PORT_A][2]};
  assign pulse_accumulator_input_o = pad_in_reg[msp_pkg::PORT_A][7];
  assign adc_inputs_o              = pad_in_reg[msp_pkg::PORT_E] & {8{adc_en_i}};

  // ---------------------------------------------------------------------------
  // Pad drivers, one per port
  // ---------------------------------------------------------------------------
  for (genvar g = 0; g < msp_pkg::NUM_PORTS; g++) begin : g_port
    msp_port_mux #(
      .PIN_MASK   (msp_pkg::msp_pin_mask(g, REDUCED_PINS)),
      .DRIVE_MASK ((g == msp_pkg::PORT_E) ? msp_pkg::NONE_MASK : msp_pkg::FULL_MASK)
    ) u_mux (
      .mclk_i      (mclk_i),
      .rst_n_i     (rst_n_i),
      .gpio_data_i (data_reg[g]),
      .gpio_dir_i  (dir_reg[g]),
      .spec_i      (spec[g]),
      .pad_o       (pad_drv[g])
    );
    assign pad_out_o[g] = pad_drv[g].out;
    assign pad_oe_o[g]  = pad_drv[g].oe;
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  sequence s_fetch_start;
    (ph_reg == msp_pkg::PH_LAST) && opcode_fetch_i && marker_allowed;
  endsequence

  sequence s_fetch_end_high;
    (ph_reg == msp_pkg::PH_LAST) && fetch_reg && !opcode_fetch_i && marker_allowed &&
    marker_drive_high_option_i;
  endsequence

  sequence s_e_cycle;
    !e_clk_o [*2] ##1 e_clk_o [*2];
  endsequence

  a_mode_capture: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_CAPTURE) |=>
      mode_valid_reg && (mode_reg == msp_pkg::msp_decode_mode($past(mode_pin_a_i),
                                                              $past(mode_pin_b_i))))
    else $error("Mode not decoded from straps.");

  a_mode_held: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    mode_valid_reg |=> mode_valid_reg && $stable(mode_reg))
    else $error("Latched mode changed.");

  a_marker_fetch: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_fetch_start |=> (opcode_fetch_marker_oe_o && !opcode_fetch_marker_o) [*4])
    else $error("Marker not low through the fetch cycle.");

  a_marker_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !marker_allowed |=> !opcode_fetch_marker_oe_o)
    else $error("Marker driven outside expanded modes.");

  a_marker_high: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_fetch_end_high |=> (opcode_fetch_marker_oe_o && opcode_fetch_marker_o) ##1
                         !opcode_fetch_marker_oe_o)
    else $error("Marker drive-high not one quarter cycle.");

  a_marker_nohigh: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !marker_drive_high_option_i |=> !(opcode_fetch_marker_oe_o && opcode_fetch_marker_o))
    else $error("Marker driven high with option off.");

  a_e_clock_shape: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ph_reg == msp_pkg::PH_LAST) |=> s_e_cycle)
    else $error("Bus clock not low then high for two ticks each.");

  a_port_e_input: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    pad_oe_o[msp_pkg::PORT_E] == 8'h00)
    else $error("Port E driven.");

  a_addr_bus: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    exp_active |=> (pad_oe_o[msp_pkg::PORT_B] == 8'hff) &&
                   (pad_out_o[msp_pkg::PORT_B] == $past(ext_addr_i[15:8])) &&
                   (pad_out_o[msp_pkg::PORT_F] == $past(ext_addr_i[7:0])))
    else $error("Address bus not on ports B and F.");

  a_rw_line: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    exp_active |=> pad_oe_o[msp_pkg::PORT_G][7] &&
                   (pad_out_o[msp_pkg::PORT_G][7] == $past(ext_rw_i)))
    else $error("Read/write line not on G7.");

  a_reduced_pins: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ((pad_out_o[msp_pkg::PORT_D] & 8'hc0) == 8'h00) && (!REDUCED_PINS ||
     (((pad_oe_o[msp_pkg::PORT_G] & 8'h7f) | (pad_oe_o[msp_pkg::PORT_H] & 8'hf0)) == 8'h00)))
    else $error("Missing port lines driven.");

  a_data_kept: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !port_wr_i |=> $stable(data_reg[msp_pkg::PORT_H]) && $stable(data_reg[msp_pkg::PORT_A]))
    else $error("Stored port data changed without a write.");

endmodule

// ==== tb/msp_board_model.sv ====
// Board model: pin levels seen by the device, with pull-ups and undriven lines.
`timescale 1ns/1ps
module msp_board_model (
  input  wire logic [7:0][7:0] pad_out_i,
  input  wire logic [7:0][7:0] pad_oe_i,
  input  wire logic            marker_i,
  input  wire logic            marker_oe_i,
  output logic      [7:0][7:0] pad_in_o,
  output logic                 marker_wire_o
);
  // An undriven line shows the inverse of its output so a stale value never passes.
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      pad_in_o[p] = (pad_oe_i[p] & pad_out_i[p]) | (~pad_oe_i[p] & ~pad_out_i[p]);
    end
  end
  // The marker line has a pull-up, so it is high whenever nothing drives it.
  assign marker_wire_o = marker_oe_i ? marker_i : 1'b1;
endmodule

// ==== tb/mode_select_and_port_mux_tb.sv ====
// Self-checking bench for the mode select and port mux block.
`timescale 1ns/1ps
module mode_select_and_port_mux_tb;
  typedef struct {logic a; logic b; msp_pkg::msp_mode_t m; logic [7:0] pb;} msp_row_t;
  logic mclk_i, rst_n_i, mode_pin_a_i, mode_pin_b_i, opcode_fetch_i, marker_drive_high_option_i;
  logic port_wr_i, port_wsel_dir_i, port_rsel_dir_i, ext_rw_i, ext_data_oe_i, ic4_select_i;
  logic pai_en_i, adc_en_i, io_chip_select_en_i, io_chip_select_i, program_chip_select_en_i;
  logic program_chip_select_i, mode_valid_o, e_clk_o, opcode_fetch_marker_o, marker_wire;
  logic opcode_fetch_marker_oe_o, pulse_accumulator_input_o;
  logic [2:0] port_waddr_i, port_raddr_i;
  logic [7:0] port_wdata_i, port_rdata_o, ext_data_out_i, ext_data_in_o, adc_inputs_o;
  logic [15:0] ext_addr_i;
  logic [18:13] ext_addr_hi_i;
  logic [5:0] ext_addr_hi_en_i, serial_en_i, serial_out_i, serial_oe_i, serial_in_o;
  logic [5:2] oc_en_i;
  logic [5:1] oc_level_i;
  logic [7:3] oc1_mask_i;
  logic [4:1] input_capture_o;
  logic [3:0] pwm_en_i, pwm_i;
  logic [7:0][7:0] pad_in_i, pad_out_o, pad_oe_o;
  msp_pkg::msp_mode_t mode_o;
  int bad_count, checks_done;
  logic [7:0] hi;
  msp_row_t rows [4] = '{'{0, 1, msp_pkg::MODE_SINGLE_CHIP, 8'h00},
    '{1, 1, msp_pkg::MODE_EXPANDED, 8'hff}, '{0, 0, msp_pkg::MODE_BOOTSTRAP, 8'h00},
    '{1, 0, msp_pkg::MODE_SPECIAL_TEST, 8'hff}};
  msp_mode_port_top dut_u (.*);
  msp_board_model board_u (.pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o), .pad_in_o(pad_in_i),
    .marker_i(opcode_fetch_marker_o), .marker_oe_i(opcode_fetch_marker_oe_o),
    .marker_wire_o(marker_wire));
  // Clock generator at 4 ns.
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  // Compares two bytes and counts the outcome.
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      bad_count++;
    end
  endtask
  // Steps a number of edges, then settles just after the last one.
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // Resets with the given straps held through the capture edge.
  task automatic do_reset(input logic a, input logic b);
    rst_n_i = 1'b0;
    mode_pin_a_i = a;
    mode_pin_b_i = b;
    cyc(8);
    rst_n_i = 1'b1;
    cyc(4);
    mode_pin_a_i = ~a;
    mode_pin_b_i = ~b;
    cyc(6);
  endtask
  // Writes the GPIO store: sel 1 picks direction, 0 data.
  task automatic wr(input logic sel, input logic [2:0] ad, input logic [7:0] d);
    port_wr_i = 1'b1;
    port_wsel_dir_i = sel;
    port_waddr_i = ad;
    port_wdata_i = d;
    cyc(1);
    port_wr_i = 1'b0;
    cyc(3);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog cuts a hang short.
  initial begin
    #40000;
    bad_count++;
    end_sim();
  end
  // Main sequence: strap rows, marker timing, then GPIO and special functions.
  initial begin
    {mode_pin_a_i, mode_pin_b_i, opcode_fetch_i, marker_drive_high_option_i} = '0;
    {port_wr_i, port_wsel_dir_i, port_waddr_i, port_wdata_i, port_rsel_dir_i, port_raddr_i} = '0;
    {ext_addr_hi_i, ext_addr_hi_en_i, ext_data_out_i, ext_data_oe_i, oc_en_i, oc_level_i} = '0;
    {oc1_mask_i, ic4_select_i, pai_en_i, serial_en_i, serial_out_i, serial_oe_i, adc_en_i} = '0;
    {pwm_en_i, pwm_i, io_chip_select_en_i, io_chip_select_i} = '0;
    {program_chip_select_en_i, program_chip_select_i} = '0;
    {ext_addr_i, ext_rw_i, bad_count, checks_done} = '0;
    rst_n_i = 1'b0;
    ext_addr_i = 16'ha5c3;
    ext_rw_i = 1'b1;
    ext_addr_hi_i = 6'h2a;
    ext_addr_hi_en_i = 6'h3f;
    opcode_fetch_i = 1'b1;
    foreach (rows[i]) begin
      do_reset(rows[i].a, rows[i].b);
      chk(mode_o, rows[i].m);
      chk(mode_valid_o, 8'h01);
      chk(pad_out_o[1] & rows[i].pb, rows[i].pb & 8'ha5);
      chk(pad_oe_o[1], rows[i].pb);
      chk(pad_out_o[6][7], rows[i].pb[0]);
      chk(pad_out_o[6], rows[i].pb & 8'haa);
      chk(pad_oe_o[6], rows[i].pb & 8'hbf);
      chk({opcode_fetch_marker_oe_o, marker_wire}, {rows[i].pb[0], ~rows[i].pb[0]});
      $display("test strap row %0d done", i);
    end
    hi = 8'h00;
    for (int k = 0; k < 8; k++) begin
      hi += e_clk_o;
      cyc(1);
    end
    chk(hi, 8'h04);
    for (int o = 0; o < 2; o++) begin
      marker_drive_high_option_i = o[0];
      opcode_fetch_i = 1'b1;
      cyc(8);
      opcode_fetch_i = 1'b0;
      hi = 8'h00;
      for (int k = 0; k < 12; k++) begin
        hi += opcode_fetch_marker_oe_o & opcode_fetch_marker_o;
        cyc(1);
      end
      chk(hi, 8'(o));
      chk({opcode_fetch_marker_oe_o, marker_wire}, 8'h01);
    end
    $display("test marker done");
    do_reset(1'b0, 1'b1);
    wr(1'b0, 3'h1, 8'h3c);
    wr(1'b1, 3'h1, 8'hff);
    chk(pad_out_o[1], 8'h3c);
    wr(1'b1, 3'h4, 8'hff);
    chk(pad_oe_o[4], 8'h00);
    port_raddr_i = 3'h1;
    cyc(2);
    chk(port_rdata_o, 8'h3c);
    wr(1'b0, 3'h7, 8'h0f);
    wr(1'b1, 3'h7, 8'hff);
    pwm_en_i = 4'hf;
    pwm_i = 4'h5;
    {program_chip_select_en_i, program_chip_select_i} = 2'h3;
    cyc(2);
    chk(pad_out_o[7], 8'h85);
    pwm_en_i = 4'h0;
    program_chip_select_en_i = 1'b0;
    cyc(2);
    chk(pad_out_o[7], 8'h0f);
    $display("test gpio done");
    chk(adc_inputs_o, 8'h00);
    adc_en_i = 1'b1;
    wr(1'b0, 3'h3, 8'hff);
    wr(1'b1, 3'h3, 8'hff);
    {serial_en_i, serial_out_i, serial_oe_i} = {6'h3f, 6'h15, 6'h3f};
    oc1_mask_i = 5'h1f;
    oc_level_i = 5'h01;
    cyc(3);
    chk(adc_inputs_o, 8'hff);
    chk(pad_out_o[3], 8'h15);
    chk(pad_oe_o[3], 8'h3f);
    chk(serial_in_o, 8'h15);
    chk(pad_out_o[0], 8'hf8);
    chk(pad_oe_o[0], 8'hf8);
    chk(input_capture_o, 8'h07);
    chk(pulse_accumulator_input_o, 8'h01);
    $display("test special functions done");
    end_sim();
  end
endmodule
